// ==== inc/decoder_pkg.sv ====
// Constants, types and decode helpers for the video decoder bring-up and input block.
// Assumes one 20 MHz clock with a synchronous active-high reset.
package decoder_pkg;

  // Register offsets; the page and soft reset registers answer in every sub map.
  localparam logic [7:0] REG_ROUTING = 8'h00;
  localparam logic [7:0] REG_SUBMAP = 8'h0E;
  localparam logic [7:0] REG_SOFT_RST = 8'h0F;
  localparam logic [7:0] REG_CONTRAST = 8'h80;

  // Field positions.
  localparam int SUBMAP_LSB = 5;
  localparam int SUBMAP_MSB = 6;
  localparam int CONTRAST_EN_BIT = 7;
  localparam int SOFT_RST_BIT = 7;
  localparam int ROUTE_W = 5;
  localparam int CHAN_COUNT = 8;

  // Sub map codes.
  localparam logic [1:0] SUBMAP_USER = 2'h0;
  localparam logic [1:0] SUBMAP_TWO = 2'h2;

  // Reset values.
  localparam logic [7:0] SUBMAP_RESET = 8'h00;
  localparam logic [4:0] ROUTING_RESET = 5'h00;
  localparam logic [7:0] CONTRAST_RESET = 8'h00;

  // Seven-bit serial address with the strap in the lowest bit.
  localparam logic [6:0] DEV_ADDR_BASE = 7'h20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Routing codes and channel masks.
  localparam logic [4:0] CODE_CVBS_LAST = 5'h07;
  localparam logic [4:0] CODE_YC_LAST = 5'h0B;
  localparam logic [4:0] CODE_YPRPB_A = 5'h0C;
  localparam logic [4:0] CODE_YPRPB_B = 5'h0D;
  localparam logic [7:0] CHAN_ONE = 8'h01;
  localparam logic [7:0] CHAN_PAIR = 8'h03;
  localparam logic [7:0] CHAN_YPRPB_A = 8'h07;
  localparam logic [7:0] CHAN_YPRPB_B = 8'h38;
  localparam logic [7:0] CHAN_UPPER = 8'hF0;
  localparam logic [7:0] CHAN_NONE = 8'h00;

  typedef enum logic [1:0] {
    FMT_CVBS = 2'b00,
    FMT_YC = 2'b01,
    FMT_YPRPB = 2'b10,
    FMT_RSVD = 2'b11
  } video_format_t;

  typedef struct packed {
    video_format_t format;
    logic [7:0] chan_on;
  } route_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_SUB = 3'b010,
    ST_WR = 3'b011,
    ST_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RACK = 3'b110
  } serial_state_t;

  // Maps a routing code to a format and the analog channels it uses.
  function automatic route_t decode_route(input logic [4:0] code, input logic eight_inputs);
    route_t r;
    r.format = FMT_RSVD;
    r.chan_on = CHAN_NONE;
    if (code <= CODE_CVBS_LAST)
    begin
      r.format = FMT_CVBS;
      r.chan_on = CHAN_ONE << code[2:0];
    end
    else if (code <= CODE_YC_LAST)
    begin
      r.format = FMT_YC;
      r.chan_on = CHAN_PAIR << {code[1:0], 1'b0};
    end
    else if (code == CODE_YPRPB_A)
    begin
      r.format = FMT_YPRPB;
      r.chan_on = CHAN_YPRPB_A;
    end
    else if (code == CODE_YPRPB_B)
    begin
      r.format = FMT_YPRPB;
      r.chan_on = CHAN_YPRPB_B;
    end
    if (!eight_inputs && ((r.chan_on & CHAN_UPPER) != CHAN_NONE))
    begin
      r.format = FMT_RSVD;
      r.chan_on = CHAN_NONE;
    end
    return r;
  endfunction

  // True where a subaddress exists in the selected sub map.
  function automatic logic reg_valid(input logic [1:0] map, input logic [7:0] addr);
    return (addr == REG_SUBMAP) || (addr == REG_SOFT_RST) ||
      ((map == SUBMAP_USER) && (addr == REG_ROUTING)) ||
      ((map == SUBMAP_TWO) && (addr == REG_CONTRAST));
  endfunction

endpackage

// ==== verilog/pin_sync.sv ====
// Three-stage synchroniser for asynchronous pins with a two-stage agreement filter.
// Assumes the pins are slow relative to the 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and filtered levels.
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;

  // A new level is taken only where the second and third stage agree.
  assign level_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_o);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_o <= RST_VAL;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_o <= level_nxt;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ==== verilog/decoder_config.sv ====
// Serial register slave, sub map paging, input routing and contrast boost control.
// Assumes open-drain SDA resolved outside; the serial clock runs far below clk_i.
`timescale 1ns/1ps
`default_nettype none

module decoder_config
  import decoder_pkg::*;
#(
  parameter bit EIGHT_INPUTS = 1'b1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control pins.
  input wire logic power_down_pin_n_i,
  input wire logic reset_pin_n_i,
  input wire logic address_select_strap_i,
  // Serial port.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Decoder core controls.
  output route_t route_o,
  output logic [CHAN_COUNT-1:0] channel_power_o,
  output logic adaptive_contrast_boost_o,
  output logic powered_down_o
);

  localparam logic [4:0] SYNC_RST = 5'h18;

  logic [4:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic pd_n_f;
  logic rst_n_f;
  logic strap_f;
  logic scl_q;
  logic sda_q;
  logic strap_r;
  logic soft_rst_r;
  logic core_rst;
  logic core_rst_q;
  logic reg_rst;
  serial_state_t state_r;
  serial_state_t state_nxt;
  serial_state_t after_r;
  serial_state_t after_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [3:0] bcnt_r;
  logic [3:0] bcnt_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic oe_nxt;
  logic [7:0] submap_r;
  logic [4:0] routing_r;
  logic [7:0] contrast_r;

  pin_sync #(
    .W(5),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({scl_i, sda_i, power_down_pin_n_i, reset_pin_n_i, address_select_strap_i}),
    .level_o(pins_f)
  );

  assign scl_f = pins_f[4];
  assign sda_f = pins_f[3];
  assign pd_n_f = pins_f[2];
  assign rst_n_f = pins_f[1];
  assign strap_f = pins_f[0];

  // The reset pin holds the whole core; soft reset clears only registers.
  assign core_rst = rst_i | ~rst_n_f;
  assign reg_rst = core_rst | soft_rst_r;

  // Bus conditions seen on the filtered levels.
  wire start_c = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_c = scl_f & scl_q & ~sda_q & sda_f;
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire byte_done = scl_fall & (bcnt_r == BITS_PER_BYTE);

  wire [1:0] map_sel = submap_r[SUBMAP_MSB:SUBMAP_LSB];
  wire addr_hit = shift_r[7:1] == (DEV_ADDR_BASE | {6'h00, strap_r});
  wire ptr_valid = reg_valid(map_sel, ptr_r);
  wire sub_valid = reg_valid(map_sel, shift_r);
  wire wr_en = (state_r == ST_WR) & byte_done & ptr_valid;

  // Read data for the pointed register; unmapped bits read zero.
  wire [7:0] rd_data = (ptr_r == REG_SUBMAP) ? submap_r :
    (ptr_r == REG_ROUTING && map_sel == SUBMAP_USER) ? {3'h0, routing_r} :
    (ptr_r == REG_CONTRAST && map_sel == SUBMAP_TWO) ? contrast_r : 8'h00;

  wire route_t route_c = decode_route(routing_r, EIGHT_INPUTS);

  always_comb
  begin
    state_nxt = state_r;
    after_nxt = after_r;
    shift_nxt = shift_r;
    bcnt_nxt = bcnt_r;
    ptr_nxt = ptr_r;
    oe_nxt = sda_oe_o;
    if (start_c)
    begin
      state_nxt = ST_DEV;
      bcnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end
    else if (stop_c)
    begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_DEV, ST_SUB, ST_WR:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_f};
            bcnt_nxt = bcnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            bcnt_nxt = 4'h0;
            state_nxt = ST_IDLE;
            if (state_r == ST_DEV && addr_hit)
            begin
              state_nxt = ST_ACK;
              after_nxt = shift_r[0] ? ST_RD : ST_SUB;
              oe_nxt = 1'b1;
            end
            else if (state_r == ST_SUB && sub_valid)
            begin
              state_nxt = ST_ACK;
              after_nxt = ST_WR;
              ptr_nxt = shift_r;
              oe_nxt = 1'b1;
            end
            else if (state_r == ST_WR && ptr_valid)
            begin
              state_nxt = ST_ACK;
              after_nxt = ST_WR;
              ptr_nxt = ptr_r + 8'h01;
              oe_nxt = 1'b1;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            state_nxt = after_r;
            bcnt_nxt = 4'h0;
            oe_nxt = 1'b0;
            if (after_r == ST_RD)
            begin
              shift_nxt = rd_data;
              bcnt_nxt = 4'h1;
              oe_nxt = ~rd_data[7];
            end
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            if (bcnt_r == BITS_PER_BYTE)
            begin
              state_nxt = ST_RACK;
              oe_nxt = 1'b0;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              bcnt_nxt = bcnt_r + 4'h1;
              oe_nxt = ~shift_r[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            state_nxt = sda_f ? ST_IDLE : ST_ACK;
            after_nxt = ST_RD;
            // Past the last register the same register keeps reading.
            if (reg_valid(map_sel, ptr_r + 8'h01))
            begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        default:
        begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      shift_r <= 8'h00;
      bcnt_r <= 4'h0;
      ptr_r <= 8'h00;
      sda_oe_o <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      shift_r <= shift_nxt;
      bcnt_r <= bcnt_nxt;
      ptr_r <= ptr_nxt;
      sda_oe_o <= oe_nxt;
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // The strap is caught in reset and one cycle after, as its filtered level settles late.
  always_ff @(posedge clk_i)
  begin
    core_rst_q <= core_rst;
    if (core_rst | core_rst_q)
    begin
      strap_r <= strap_f;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reg_rst)
    begin
      submap_r <= SUBMAP_RESET;
      routing_r <= ROUTING_RESET;
      contrast_r <= CONTRAST_RESET;
      soft_rst_r <= 1'b0;
    end
    else
    begin
      soft_rst_r <= wr_en & (ptr_r == REG_SOFT_RST) & shift_r[SOFT_RST_BIT];
      if (wr_en && ptr_r == REG_SUBMAP)
      begin
        submap_r <= shift_r;
      end
      if (wr_en && ptr_r == REG_ROUTING)
      begin
        routing_r <= shift_r[ROUTE_W-1:0];
      end
      if (wr_en && ptr_r == REG_CONTRAST)
      begin
        contrast_r <= shift_r;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      route_o <= '{format: FMT_CVBS, chan_on: CHAN_NONE};
      channel_power_o <= CHAN_NONE;
      adaptive_contrast_boost_o <= 1'b0;
      powered_down_o <= 1'b1;
      sda_o <= 1'b0;
    end
    else
    begin
      route_o <= route_c;
      channel_power_o <= (pd_n_f & rst_n_f) ? route_c.chan_on : CHAN_NONE;
      adaptive_contrast_boost_o <= contrast_r[CONTRAST_EN_BIT];
      powered_down_o <= ~pd_n_f;
      sda_o <= 1'b0;
    end
  end

endmodule // decoder_config

`default_nettype wire

// ==== tb/decoder_config_props.sv ====
// Port checker for the decoder configuration block.
// Bound to decoder_config; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module decoder_config_props
  import decoder_pkg::*;
(
  // Clock, reset and serial pins.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  // Core controls.
  input wire route_t route_o,
  input wire logic [CHAN_COUNT-1:0] channel_power_o,
  input wire logic adaptive_contrast_boost_o,
  input wire logic powered_down_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic [7:0] c = route_o.chan_on;
  wire logic [7:0] p = channel_power_o;

  a_chan_off:
  assert property (powered_down_o [*3] |-> p == CHAN_NONE)
    else $error("channel powered while down");
  a_chan_match:
  assert property (p != CHAN_NONE |-> p == c || p == $past(c))
    else $error("powered channels differ from routing");
  a_cvbs_single:
  assert property (route_o.format == FMT_CVBS |-> $onehot0(c))
    else $error("composite uses several channels");
  a_yc_pair:
  assert property (route_o.format == FMT_YC |-> c inside {8'h03, 8'h0C, 8'h30, 8'hC0})
    else $error("bad S-Video pair");
  a_yprpb_trio:
  assert property (route_o.format == FMT_YPRPB |-> c inside {8'h07, 8'h38})
    else $error("bad component trio");
  a_rsvd_none:
  assert property (route_o.format == FMT_RSVD |-> c == CHAN_NONE)
    else $error("reserved code powers a channel");
  a_reset_clear:
  assert property ($fell(rst_i) |-> !adaptive_contrast_boost_o && powered_down_o && p == 8'h00)
    else $error("outputs not cleared by reset");
  a_ack_scl_low:
  assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data pulled low while clock high");

  cover property (route_o.format == FMT_YC);
  cover property ($rose(adaptive_contrast_boost_o));
  cover property ($rose(sda_oe_o));
endmodule // decoder_config_props

bind decoder_config decoder_config_props decoder_config_props_inst (.*);
`default_nettype wire

// ==== tb/host_model.sv ====
// Host model: bring-up pins and serial register writes.
// Assumes SDA and SCL are resolved outside with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module host_model #(
  parameter int MS = 40,
  parameter int P = 8
) (
  // Clock.
  input wire logic clk_i,
  // Pins.
  output logic pd_n_o,
  output logic rst_n_o,
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  initial
  begin
    pd_n_o = 1'b0;
    rst_n_o = 1'b0;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic power_up();
    hold(MS);
    pd_n_o = 1'b1;
    hold(5 * MS);
    rst_n_o = 1'b1;
    hold(5 * MS);
  endtask

  task automatic set_pd(input logic v);
    pd_n_o = v;
    hold(8);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_o = (i > 0) ? b[i-1] : 1'b1;
      hold(P);
      scl_o = 1'b1;
      hold(P);
      ack = ~sda_i;
      scl_o = 1'b0;
      hold(P);
    end
  endtask

  task automatic write_reg(input logic [7:0] dev, sub, data, output logic ok);
    logic a0, a1, a2;
    sda_o = 1'b0;
    hold(P);
    scl_o = 1'b0;
    hold(P);
    put_byte(dev, a0);
    put_byte(sub, a1);
    put_byte(data, a2);
    sda_o = 1'b0;
    hold(P);
    scl_o = 1'b1;
    hold(P);
    sda_o = 1'b1;
    hold(P);
    ok = a0 & a1 & a2;
  endtask

  // Takes eight data bits, then answers on the ninth clock.
  task automatic get_byte(input logic last, output logic [7:0] b);
    for (int i = 8; i >= 0; i--)
    begin
      sda_o = (i > 0) ? 1'b1 : ~last;
      hold(P);
      scl_o = 1'b1;
      hold(P);
      if (i > 0)
        b[i-1] = sda_i;
      scl_o = 1'b0;
      hold(P);
    end
  endtask

  // Pointer write, repeated start, one byte read and a closing acknowledge.
  task automatic read_reg(input logic [7:0] dev, sub, output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    sda_o = 1'b0;
    hold(P);
    scl_o = 1'b0;
    hold(P);
    put_byte(dev, a0);
    put_byte(sub, a1);
    sda_o = 1'b1;
    hold(P);
    scl_o = 1'b1;
    hold(P);
    sda_o = 1'b0;
    hold(P);
    scl_o = 1'b0;
    hold(P);
    put_byte(dev | 8'h01, a2);
    get_byte(1'b1, data);
    sda_o = 1'b0;
    hold(P);
    scl_o = 1'b1;
    hold(P);
    sda_o = 1'b1;
    hold(P);
    ok = a0 & a1 & a2;
  endtask

  // page to sub map 2, set boost, page back
  task automatic boost_seq(input logic [7:0] v, output logic ok);
    logic a, b, d;
    write_reg(8'h40, 8'h0E, 8'h40, a);
    write_reg(8'h40, 8'h80, v, b);
    write_reg(8'h40, 8'h0E, 8'h00, d);
    ok = a & b & d;
  endtask

  // software reset, then the long wait
  task automatic soft_reset(output logic ok);
    write_reg(8'h40, 8'h0F, 8'h80, ok);
    hold(10 * MS);
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/decoder_bringup_and_input_config_test.sv ====
// Self-checking bench for the decoder configuration block.
// Host model drives pins; the bench resolves the data wire.
`timescale 1ns/1ps
`default_nettype none

module decoder_bringup_and_input_config_test;
  import decoder_pkg::*;
  logic clk_i, rst_i, strap, pd_n, rst_n, scl, h_sda, sda_o, sda_oe, boost, pdown, ok;
  logic [7:0] chan, d;
  logic [15:0] lfsr_r;
  route_t route;
  int n_errors, num_checks, e_code, e_boost, e_pd;
  wire logic sda_w = h_sda & ~sda_oe;

  decoder_config #(.EIGHT_INPUTS(1'b1)) decoder_config_inst (
    .clk_i(clk_i), .rst_i(rst_i), .power_down_pin_n_i(pd_n), .reset_pin_n_i(rst_n),
    .address_select_strap_i(strap), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .route_o(route), .channel_power_o(chan),
    .adaptive_contrast_boost_o(boost), .powered_down_o(pdown));
  host_model host_model_inst (.clk_i(clk_i), .pd_n_o(pd_n), .rst_n_o(rst_n),
    .scl_o(scl), .sda_o(h_sda), .sda_i(sda_w));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [9:0] exp_route(input int c);
    if (c < 8) return {2'h0, 8'(1 << c)};
    if (c < 12) return {2'h1, 8'(3 << (2 * (c - 8)))};
    if (c == 12) return {2'h2, 8'h07};
    if (c == 13) return {2'h2, 8'h38};
    return {2'h3, 8'h00};
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmp_model();
    logic [9:0] r;
    repeat (6) @(posedge clk_i);
    #1;
    r = exp_route(e_code);
    check({6'h00, route}, {6'h00, r});
    check({8'h00, chan}, {8'h00, (e_pd != 0) ? 8'h00 : r[7:0]});
    check({15'h0000, boost}, 16'(e_boost));
    check({15'h0000, pdown}, 16'(e_pd));
    check({15'h0000, sda_o}, 16'h0000);
  endtask

  task automatic rd(input logic [7:0] dv, sb, exp);
    logic [7:0] v;
    host_model_inst.read_reg(dv, sb, v, ok);
    check({7'h00, ok, v}, {8'h01, exp});
  endtask

  task automatic wr(input logic [7:0] dv, sb, dt, input logic exp_ok);
    host_model_inst.write_reg(dv, sb, dt, ok);
    check({15'h0000, ok}, {15'h0000, exp_ok});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    {rst_i, strap, e_code, e_boost, e_pd, lfsr_r} = {1'b1, 1'b0, 96'h0, 16'h3FC2};
    n_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    host_model_inst.power_up();
    cmp_model();
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      d = (i < 32) ? 8'(i) : lfsr_r[7:0];
      wr(8'h40, 8'h00, d, 1'b1);
      e_code = d[4:0];
      cmp_model();
    end
    rd(8'h40, 8'h00, {3'h0, d[4:0]});
    $display("test routing done");
    wr(8'h42, 8'h00, 8'h05, 1'b0);
    wr(8'h40, 8'h80, 8'h80, 1'b0);
    cmp_model();
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : lfsr_r[15:8] | 8'h80;
      host_model_inst.boost_seq(d, ok);
      check({15'h0000, ok}, 16'h0001);
      e_boost = d[7];
      cmp_model();
    end
    rd(8'h40, 8'h0E, 8'h00);
    wr(8'h40, 8'h0E, 8'h40, 1'b1);
    wr(8'h40, 8'h00, 8'h03, 1'b0);
    wr(8'h40, 8'h0E, 8'h00, 1'b1);
    cmp_model();
    $display("test boost done");
    e_pd = 1;
    host_model_inst.set_pd(1'b0);
    cmp_model();
    e_pd = 0;
    host_model_inst.set_pd(1'b1);
    cmp_model();
    host_model_inst.soft_reset(ok);
    check({15'h0000, ok}, 16'h0001);
    {e_code, e_boost} = 64'h0;
    cmp_model();
    $display("test power done");
    wr(8'h40, 8'h00, 8'h09, 1'b1);
    strap = 1'b1;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    e_code = 0;
    cmp_model();
    wr(8'h40, 8'h00, 8'h02, 1'b0);
    wr(8'h42, 8'h00, 8'h0A, 1'b1);
    e_code = 10;
    cmp_model();
    rd(8'h42, 8'h00, 8'h0A);
    $display("test strap done");
    print_verdict();
  end
endmodule // decoder_bringup_and_input_config_test
`default_nettype wire
